// *** inc/kwdt_pkg.sv ***
// Constants, register map and field layout of the keyed watchdog timer
package kwdt_pkg;
	// Register bus geometry
	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;

	// Register offsets
	localparam logic [2:0] ADR_CTRL = 3'h0;
	localparam logic [2:0] ADR_CAUSE = 3'h1;
	localparam logic [2:0] ADR_STAT = 3'h2;
	localparam logic [2:0] ADR_IRQ_ST = 3'h3;
	localparam logic [2:0] ADR_IRQ_MSK = 3'h4;

	// Control register layout: key in bits 7..3, period select in 2..0
	localparam int KEY_LSB = 3;
	localparam int KEY_W = 5;
	localparam int SEL_W = 3;
	localparam logic [7:0] CTRL_POR = 8'h53;
	localparam logic [4:0] KEY_DISABLE = 5'h15;
	localparam logic [4:0] KEY_ENABLE = 5'h0A;

	// Cause register: key reset flag bit
	localparam int CAUSE_KEY_BIT = 0;

	// Status register bits
	localparam int STAT_TO_BIT = 0;
	localparam int STAT_PD_BIT = 1;
	localparam int STAT_RUN_BIT = 2;

	// Interrupt status / mask bits
	localparam int IRQ_W = 2;
	localparam int IRQ_OVF_BIT = 0;
	localparam int IRQ_KEY_BIT = 1;

	// Counter width covers the longest period of 2^18 slow ticks
	localparam int CNT_W = 18;

	// Delay before a bad key turns into a device reset
	localparam int CLK_PERIOD_NS = 50;
	localparam int KEY_RST_NS = 10000;
	localparam int KEY_RST_CYC = (KEY_RST_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
endpackage

// *** inc/kwdt_tick_if.sv ***
// Slow oscillator tick carried from the synchroniser to the counter
interface kwdt_tick_if;
	// One fast-clock pulse per slow oscillator rising edge
	logic tick;
	modport src (output tick);
	modport dst (input tick);
endinterface

// *** rtl/kwdt_low_speed_rc_oscillator_sync.sv ***
// Synchroniser and edge detector for the slow RC oscillator clock
module kwdt_slow_sync (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// Slow oscillator pin
	input wire logic i_slow_clk,
	// Tick towards the counter
	kwdt_tick_if.src o_tick
);
	logic sync1_q; // First stage, read only by the second
	logic sync2_q; // Second stage, safe to use
	logic prev_q; // Previous settled level for edge detection

	////////////////////////////////////////////////////////////////////////
	// Two-stage synchroniser; the slow clock is far below 20 MHz
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			prev_q <= 1'b0;
		end else begin
			sync1_q <= i_slow_clk;
			sync2_q <= sync1_q;
			prev_q <= sync2_q;
		end
	end

	// Tick on each settled rising edge, one cycle wide
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_tick.tick <= 1'b0;
		end else begin
			o_tick.tick <= sync2_q & ~prev_q;
		end
	end
endmodule

// *** rtl/kwdt_top.sv ***
// Keyed watchdog timer: registers, counter, key check and resets
//
// Notes on behaviour
// - Count only slow RC oscillator ticks.
// - Select field picks period 2^8 to 2^18.
// - Key 10101 stops, 01010 runs.
// - Other key gives delayed full reset.
// - Bad key reset sets key reset flag.
// - Only software zero write clears flag.
// - Power-on control holds key 01010, select 011.
// - Running overflow: device reset, timeout flag.
// - Low-power overflow: PC/SP reset, timeout flag.
// - Bad key, clear, halt, pin reset clear count.
// - Clear or halt instruction restarts from software.
// - Cause register upper nibble reads zero.
// - Halt clears; counting follows enable key.
// - Power down flag: halt sets, clear clears.
module kwdt_top (
	// Clock and reset
	input wire logic I_MCLK,
	input wire logic I_NRST,
	// Register port
	input wire logic [kwdt_pkg::ADDR_W-1:0] I_ADDR,
	input wire logic [kwdt_pkg::DATA_W-1:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	output logic [kwdt_pkg::DATA_W-1:0] O_RDATA,
	// Processor events, same clock
	input wire logic I_CLEAR_WD,
	input wire logic I_HALT,
	input wire logic I_LOW_POWER,
	input wire logic I_RSTPIN_SEL,
	// Pins from outside the clock domain
	input wire logic I_SLOW_CLK,
	input wire logic I_EXT_RST_N,
	// Reset requests and interrupt
	output logic O_DEV_RST,
	output logic O_PCSP_RST,
	output logic O_IRQ
);
	import kwdt_pkg::*;

	// Local copy of the delay so the checks can use a plain int bound
	localparam int SRST_WAIT = KEY_RST_CYC;

	////////////////////////////////////////////////////////////////////////
	// Declarations
	kwdt_tick_if tick_if (); // Slow tick from the synchroniser
	logic [7:0] ctrl_q; // Control register: key and period select
	logic [CNT_W-1:0] cnt_q; // Watchdog counter
	logic [CNT_W-1:0] cnt_d; // Next counter value
	logic [CNT_W-1:0] top_mask; // Last count of the selected period
	logic [4:0] shift; // Power of two of the period
	logic [4:0] key; // Enable key field
	logic key_run; // Key holds the run code
	logic key_stop; // Key holds the stop code
	logic key_bad; // Key holds neither code
	logic pend_q; // Bad key seen, reset delay running
	logic [15:0] dly_q; // Reset delay counter
	logic key_fire; // Delay spent, reset now
	logic ovf; // Counter overflow this cycle
	logic clr_evt; // Any event that clears the counter
	logic pin_s1_q; // Reset pin, first sync stage
	logic pin_s2_q; // Reset pin, second sync stage
	logic pin_rst; // Reset pin low with its function chosen
	logic key_flag_q; // Key reset flag, cause bit 0
	logic to_q; // Timeout status flag
	logic pd_q; // Power down flag
	logic [IRQ_W-1:0] irq_st_q; // Sticky interrupt events
	logic [IRQ_W-1:0] irq_msk_q; // Interrupt mask, 1 enables
	logic [IRQ_W-1:0] irq_set; // Events raised this cycle
	logic [7:0] rd_mux; // Read data before the output flop
	logic wr_ctrl; // Write to control register
	logic wr_cause; // Write to cause register
	logic wr_irq_st; // Write to interrupt status
	logic wr_irq_msk; // Write to interrupt mask

	////////////////////////////////////////////////////////////////////////
	// Slow oscillator tick
	kwdt_slow_sync kwdt_slow_sync_inst (
		.i_clk (I_MCLK),
		.i_nrst (I_NRST),
		.i_slow_clk (I_SLOW_CLK),
		.o_tick (tick_if.src)
	);

	////////////////////////////////////////////////////////////////////////
	// External reset pin synchroniser
	always_ff @(posedge I_MCLK or negedge I_NRST) begin
		if (!I_NRST) begin
			pin_s1_q <= 1'b1;
			pin_s2_q <= 1'b1;
		end else begin
			pin_s1_q <= I_EXT_RST_N;
			pin_s2_q <= pin_s1_q;
		end
	end

	// Pin only counts when the pin function is selected
	assign pin_rst = ~pin_s2_q & I_RSTPIN_SEL;

	////////////////////////////////////////////////////////////////////////
	// Write decode
	assign wr_ctrl = I_WR & (I_ADDR == ADR_CTRL);
	assign wr_cause = I_WR & (I_ADDR == ADR_CAUSE);
	assign wr_irq_st = I_WR & (I_ADDR == ADR_IRQ_ST);
	assign wr_irq_msk = I_WR & (I_ADDR == ADR_IRQ_MSK);

	////////////////////////////////////////////////////////////////////////
	// Key decode
	assign key = ctrl_q[KEY_LSB +: KEY_W];
	assign key_run = (key == KEY_ENABLE);
	assign key_stop = (key == KEY_DISABLE);
	assign key_bad = ~key_run & ~key_stop;

	// Period select to a power of two
	always_comb begin
		unique case (ctrl_q[SEL_W-1:0])
			3'h0: shift = 5'd8;
			3'h1: shift = 5'd10;
			3'h2: shift = 5'd12;
			3'h3: shift = 5'd14;
			3'h4: shift = 5'd15;
			3'h5: shift = 5'd16;
			3'h6: shift = 5'd17;
			3'h7: shift = 5'd18;
		endcase
	end

	// Highest count before the wrap
	assign top_mask = CNT_W'((19'h1 << shift) - 19'h1);

	////////////////////////////////////////////////////////////////////////
	// Control register; a bad-key reset returns it to its power-on value
	always_ff @(posedge I_MCLK or negedge I_NRST) begin
		if (!I_NRST) begin
			ctrl_q <= CTRL_POR;
		end else if (key_fire) begin
			ctrl_q <= CTRL_POR;
		end else if (wr_ctrl) begin
			ctrl_q <= I_WDATA;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bad key delay; once started it runs out even if the key is mended,
	// since noise that hit the key may have hit other state too
	always_ff @(posedge I_MCLK or negedge I_NRST) begin
		if (!I_NRST) begin
			pend_q <= 1'b0;
			dly_q <= 16'h0000;
		end else if (key_fire) begin
			pend_q <= 1'b0;
			dly_q <= 16'h0000;
		end else if (pend_q) begin
			dly_q <= dly_q + 16'h0001;
		end else if (key_bad) begin
			pend_q <= 1'b1;
			dly_q <= 16'h0001;
		end
	end

	// Fires once the full delay has passed
	assign key_fire = pend_q & (dly_q == 16'(KEY_RST_CYC));

	////////////////////////////////////////////////////////////////////////
	// Counter clear sources
	assign clr_evt = key_fire | I_CLEAR_WD | I_HALT | pin_rst;

	// Overflow when the last count of the period sees another tick
	assign ovf = key_run & tick_if.tick & ~clr_evt
		& (cnt_q == top_mask);

	// Next count: clear, wrap, advance or hold
	always_comb begin
		cnt_d = cnt_q;
		if (clr_evt) begin
			cnt_d = '0;
		end else if (ovf) begin
			cnt_d = '0;
		end else if (key_run && tick_if.tick) begin
			cnt_d = cnt_q + CNT_W'(1);
		end
	end

	// Counter register; stopped key just holds the value
	always_ff @(posedge I_MCLK or negedge I_NRST) begin
		if (!I_NRST) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Reset request pulses
	always_ff @(posedge I_MCLK or negedge I_NRST) begin
		if (!I_NRST) begin
			O_DEV_RST <= 1'b0;
			O_PCSP_RST <= 1'b0;
		end else begin
			// Full reset for bad key or running overflow
			O_DEV_RST <= key_fire | (ovf & ~I_LOW_POWER);
			// Light reset when sleeping or idle
			O_PCSP_RST <= ovf & I_LOW_POWER & ~key_fire;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Key reset flag: set wins over a software clear
	always_ff @(posedge I_MCLK or negedge I_NRST) begin
		if (!I_NRST) begin
			key_flag_q <= 1'b0;
		end else if (key_fire) begin
			key_flag_q <= 1'b1;
		end else if (wr_cause && !I_WDATA[CAUSE_KEY_BIT]) begin
			key_flag_q <= 1'b0;
		end
	end

	// Timeout flag: set on overflow, cleared by clear or halt
	always_ff @(posedge I_MCLK or negedge I_NRST) begin
		if (!I_NRST) begin
			to_q <= 1'b0;
		end else if (ovf) begin
			to_q <= 1'b1;
		end else if (I_CLEAR_WD || I_HALT) begin
			to_q <= 1'b0;
		end
	end

	// Power down flag: halt sets it, clear instruction clears it
	always_ff @(posedge I_MCLK or negedge I_NRST) begin
		if (!I_NRST) begin
			pd_q <= 1'b0;
		end else if (I_HALT) begin
			pd_q <= 1'b1;
		end else if (I_CLEAR_WD) begin
			pd_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupts: sticky, write one to clear, new event wins
	assign irq_set = {key_fire, ovf};

	always_ff @(posedge I_MCLK or negedge I_NRST) begin
		if (!I_NRST) begin
			irq_st_q <= '0;
		end else if (wr_irq_st) begin
			irq_st_q <= (irq_st_q & ~I_WDATA[IRQ_W-1:0]) | irq_set;
		end else begin
			irq_st_q <= irq_st_q | irq_set;
		end
	end

	// Mask register
	always_ff @(posedge I_MCLK or negedge I_NRST) begin
		if (!I_NRST) begin
			irq_msk_q <= '0;
		end else if (wr_irq_msk) begin
			irq_msk_q <= I_WDATA[IRQ_W-1:0];
		end
	end

	// Level output, one cycle behind the status bits
	always_ff @(posedge I_MCLK or negedge I_NRST) begin
		if (!I_NRST) begin
			O_IRQ <= 1'b0;
		end else begin
			O_IRQ <= |(irq_st_q & irq_msk_q);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read mux; unmapped addresses read zero
	always_comb begin
		rd_mux = 8'h00;
		unique case (I_ADDR)
			ADR_CTRL: rd_mux = ctrl_q;
			ADR_CAUSE: rd_mux = {7'h00, key_flag_q};
			ADR_STAT: rd_mux = {5'h00, key_run, pd_q, to_q};
			ADR_IRQ_ST: rd_mux = {6'h00, irq_st_q};
			ADR_IRQ_MSK: rd_mux = {6'h00, irq_msk_q};
			default: rd_mux = 8'h00;
		endcase
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge I_MCLK or negedge I_NRST) begin
		if (!I_NRST) begin
			O_RDATA <= 8'h00;
		end else if (I_RD) begin
			O_RDATA <= rd_mux;
		end else begin
			O_RDATA <= 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge I_MCLK); endclocking
	default disable iff (!I_NRST);

	// Stop key freezes the count unless something clears it
	chk_stop_holds: assert property (
		(key_stop && !clr_evt) |=> (cnt_q == $past(cnt_q)))
	else $error("counter moved with stop key");

	// Overflow only at the last count of the selected period
	chk_ovf_at_top: assert property (
		ovf |-> (cnt_q == top_mask) ##1 (cnt_q == '0))
	else $error("overflow not at period end");

	// Bad key leads to a full reset within the delay
	chk_bad_key_delay: assert property (
		$rose(pend_q) |-> ##[1:SRST_WAIT] O_DEV_RST)
	else $error("bad key reset late");

	// Bad key reset raises the key reset flag
	chk_key_flag_set: assert property (
		key_fire |=> key_flag_q ##0 (ctrl_q == CTRL_POR))
	else $error("key flag or control not set on key reset");

	// Flag survives anything but a software zero write
	chk_key_flag_keep: assert property (
		(key_flag_q && !(wr_cause && !I_WDATA[CAUSE_KEY_BIT]))
		|=> key_flag_q)
	else $error("key flag lost without software");

	// Running overflow gives full reset and timeout flag
	chk_run_ovf: assert property (
		(ovf && !I_LOW_POWER) |=> (O_DEV_RST && to_q && !O_PCSP_RST))
	else $error("running overflow handled wrong");

	// Low-power overflow gives only the light reset
	chk_idle_ovf: assert property (
		(ovf && I_LOW_POWER && !key_fire)
		|=> (O_PCSP_RST && to_q && !O_DEV_RST))
	else $error("idle overflow handled wrong");

	// Any clear source zeroes the counter
	chk_clear_zero: assert property (
		clr_evt |=> (cnt_q == '0))
	else $error("counter not cleared");

	// Halt sets power down; clear alone drops it
	chk_pd_flag: assert property (
		(I_HALT |=> pd_q) and ((I_CLEAR_WD && !I_HALT) |=> !pd_q))
	else $error("power down flag wrong");

	// Cause register upper nibble reads zero
	chk_cause_upper: assert property (
		(I_RD && I_ADDR == ADR_CAUSE) |=> ((O_RDATA[7:4] == 4'h0)
		&& (O_RDATA[CAUSE_KEY_BIT] == $past(key_flag_q))))
	else $error("cause upper bits not zero");
endmodule

// *** test/keyed_watchdog_timer_tb.sv ***
// Self-checking bench for the keyed watchdog timer
module keyed_watchdog_timer_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import kwdt_pkg::*;

	////////////////////////////////////////////////////////////////////
	// Stimulus and observed outputs
	logic mclk, nrst, wr, rd, clr, halt, low_pwr, pin_sel, slow, pin_n;
	logic [ADDR_W-1:0] addr, ua;
	logic [DATA_W-1:0] wdata, rdata, rv;
	logic dev_rst, pcsp_rst, irq;
	// Bench counters; d0 and p0 mark the start of a scenario
	int n_fail, checks_done, n_dev, n_pcsp, d0, p0, r;
	logic [4:0] key;

	kwdt_top kwdt_top_inst (
		.I_MCLK(mclk), .I_NRST(nrst), .I_ADDR(addr), .I_WDATA(wdata),
		.I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_CLEAR_WD(clr),
		.I_HALT(halt), .I_LOW_POWER(low_pwr), .I_RSTPIN_SEL(pin_sel),
		.I_SLOW_CLK(slow), .I_EXT_RST_N(pin_n), .O_DEV_RST(dev_rst),
		.O_PCSP_RST(pcsp_rst), .O_IRQ(irq)
	);

	////////////////////////////////////////////////////////////////////
	// 20 MHz clock
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	// Count reset request pulses as they are sampled
	always @(posedge mclk) begin
		if (dev_rst === 1'b1)
			n_dev++;
		if (pcsp_rst === 1'b1)
			n_pcsp++;
	end

	////////////////////////////////////////////////////////////////////
	// Compare one value, report at once
	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	// One-cycle write strobe
	task automatic wr_reg(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
		@(posedge mclk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge mclk);
		wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd_reg(logic [ADDR_W-1:0] a, output logic [7:0] d);
		@(posedge mclk);
		rd <= 1'b1;
		addr <= a;
		@(posedge mclk);
		rd <= 1'b0;
		@(negedge mclk);
		d = rdata;
	endtask

	// One-cycle clear or halt instruction
	task automatic instr(bit is_halt);
		@(posedge mclk);
		if (is_halt)
			halt <= 1'b1;
		else
			clr <= 1'b1;
		@(posedge mclk);
		halt <= 1'b0;
		clr <= 1'b0;
	endtask

	// Slow oscillator edges, four fast cycles each, then let sync settle
	task automatic ticks(int n);
		repeat (n) begin
			@(posedge mclk);
			slow <= 1'b1;
			repeat (2) @(posedge mclk);
			slow <= 1'b0;
			@(posedge mclk);
		end
		repeat (8) @(posedge mclk);
	endtask

	// Set key and select, restart the count, mark pulse counters
	task automatic arm(logic [4:0] k, logic [2:0] sel);
		wr_reg(ADR_CTRL, {k, sel});
		instr(1'b0);
		d0 = n_dev;
		p0 = n_pcsp;
	endtask

	// Pulses seen since the mark
	task automatic resets(string what, int dev, int pcsp);
		check({what, " dev"}, n_dev - d0, dev);
		check({what, " pcsp"}, n_pcsp - p0, pcsp);
	endtask

	// Expected overflow period in slow ticks for a select code
	function automatic int period(int sel);
		return (sel < 4) ? (1 << (8 + 2 * sel)) : (1 << (11 + sel));
	endfunction

	task automatic done(string t);
		$display("Test %s finished", t);
	endtask

	// Verdict and end of run
	task automatic close_out();
		$display("Checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Hang guard, well beyond the expected run length
	initial begin
		repeat (90000) @(posedge mclk);
		n_fail++;
		close_out();
	end

	////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{wr, rd, clr, halt, low_pwr, pin_sel, slow} = '0;
		pin_n = 1'b1;
		nrst = 1'b0;
		addr = '0;
		wdata = '0;
		r = $urandom(29);
		repeat (2) @(posedge mclk);
		nrst <= 1'b1;
		// Reset values, an unmapped place, every select code
		rd_reg(ADR_CTRL, rv);
		check("ctrl por", rv, CTRL_POR);
		rd_reg(ADR_CAUSE, rv);
		check("cause por", rv, 0);
		ua = 3'h5 + 3'($urandom % 3);
		wr_reg(ua, 8'($urandom));
		rd_reg(ua, rv);
		check("unmapped", rv, 0);
		for (int s = 0; s < 8; s++) begin
			wr_reg(ADR_CTRL, {KEY_ENABLE, 3'(s)});
			rd_reg(ADR_CTRL, rv);
			check("select", rv, {KEY_ENABLE, 3'(s)});
		end
		done("registers");
		// Fast clock alone must not advance the count
		wr_reg(ADR_IRQ_MSK, 8'h00);
		arm(KEY_ENABLE, 3'h0);
		repeat (400) @(posedge mclk);
		resets("no slow clock", 0, 0);
		// Overflow exactly at the selected period
		for (int s = 0; s < 3; s++) begin
			arm(KEY_ENABLE, 3'(s));
			ticks(period(s) - 1);
			resets("early", 0, 0);
			ticks(1);
			resets("overflow", 1, 0);
			rd_reg(ADR_STAT, rv);
			check("timeout flag", rv[STAT_TO_BIT], 1);
		end
		done("periods");
		// Masked, unmasked and cleared interrupt
		check("masked irq", irq, 0);
		rd_reg(ADR_IRQ_ST, rv);
		check("irq status", rv, 8'h01);
		wr_reg(ADR_IRQ_MSK, 8'h03);
		repeat (2) @(posedge mclk);
		@(negedge mclk);
		check("irq on", irq, 1);
		wr_reg(ADR_IRQ_ST, 8'h01);
		repeat (2) @(posedge mclk);
		@(negedge mclk);
		check("irq off", irq, 0);
		done("interrupt");
		// Overflow while asleep resets only PC and SP
		@(posedge mclk);
		low_pwr <= 1'b1;
		arm(KEY_ENABLE, 3'h0);
		ticks(256);
		resets("sleep", 0, 1);
		rd_reg(ADR_STAT, rv);
		check("sleep timeout", rv[STAT_TO_BIT], 1);
		@(posedge mclk);
		low_pwr <= 1'b0;
		done("sleep");
		// Clear, halt, selected pin; an unselected pin must not clear
		for (int src = 0; src < 4; src++) begin
			arm(KEY_ENABLE, 3'h0);
			r = 100 + $urandom % 150;
			ticks(r);
			if (src < 2) begin
				instr(src[0]);
			end else begin
				@(posedge mclk);
				pin_sel <= (src == 2);
				pin_n <= 1'b0;
				repeat (4) @(posedge mclk);
				pin_n <= 1'b1;
				repeat (4) @(posedge mclk);
				pin_sel <= 1'b0;
			end
			ticks(306 - r);
			resets("clear source", src == 3, 0);
			// Counting resumes from zero: 256 ticks after the clear
			ticks(r - 50);
			resets("resumed count", 1, 0);
		end
		instr(1'b1);
		rd_reg(ADR_STAT, rv);
		check("halt flags", rv[1:0], 2'b10);
		instr(1'b0);
		rd_reg(ADR_STAT, rv);
		check("clear power down", rv[STAT_PD_BIT], 0);
		done("clears");
		// Disable key holds the count, enable key resumes it
		arm(KEY_DISABLE, 3'h0);
		ticks(300);
		resets("held", 0, 0);
		rd_reg(ADR_STAT, rv);
		check("stopped", rv[STAT_RUN_BIT], 0);
		wr_reg(ADR_CTRL, {KEY_ENABLE, 3'h0});
		ticks(256);
		resets("resumed", 1, 0);
		done("keys");
		// Undefined key: delayed reset, sticky flag
		do
			key = 5'($urandom);
		while (key == KEY_ENABLE || key == KEY_DISABLE);
		arm(KEY_ENABLE, 3'h0);
		wr_reg(ADR_CTRL, {key, 3'h0});
		repeat (KEY_RST_CYC - 5) @(posedge mclk);
		resets("key early", 0, 0);
		repeat (10) @(posedge mclk);
		resets("key reset", 1, 0);
		rd_reg(ADR_CTRL, rv);
		check("ctrl restored", rv, CTRL_POR);
		rd_reg(ADR_CAUSE, rv);
		check("key flag", rv, 8'h01);
		rd_reg(ADR_IRQ_ST, rv);
		check("key irq", rv[IRQ_KEY_BIT], 1);
		wr_reg(ADR_CAUSE, 8'hFF);
		rd_reg(ADR_CAUSE, rv);
		check("flag kept", rv, 8'h01);
		wr_reg(ADR_CAUSE, 8'h00);
		rd_reg(ADR_CAUSE, rv);
		check("flag cleared", rv, 8'h00);
		done("bad key");
		close_out();
	end
endmodule
